// File: bsc_top.sv
// Function
// - min on/off pulse widths per frequency band
// - only strapped in-use sinks are evaluated
// - open or shorted strings leave the loop
// - raise target when any sink below headroom
// - lower target until a sink reaches headroom
// - ramp to 88% initial level before channels active
// - low overvoltage: stop switching, flag, sinks run
// - high overvoltage: fault recovery and flag
// - undervoltage 110 ms timer then recovery and flag
// - no sync clock: pin level sets spread spectrum
// - sync clock present: switch from external clock
// - sync clock lost: internal clock, final level
// - detect sync clock at start, else internal
// - sync 100 to 2222 kHz, spread off
//
// The address map and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module bsc_top
  import bsc_pkg::*;
#(
  parameter int unsigned TW             = 8,
  parameter int unsigned NCH            = 4,
  parameter logic [7:0]  TGT_MIN        = 8'h00,
  parameter logic [7:0]  TGT_MAX        = 8'hFF,
  parameter int unsigned UV_TIMEOUT_CYCLES = bsc_pkg::UV_TIMEOUT_CYC
)(
  input  wire logic            hclk,
  input  wire logic            hresetn,
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic [31:0]     hwdata,
  input  wire logic            hready,
  output logic      [31:0]     hrdata,
  output logic                 hreadyout,
  output logic                 hresp,
  input  wire logic            boost_clock_sync_pin,
  input  wire logic [NCH-1:0]  string_config_strap,
  input  wire logic [NCH-1:0]  string_fault,
  input  wire logic [NCH-1:0]  sink_below_headroom,
  input  wire logic [NCH-1:0]  sink_at_headroom,
  input  wire logic            channels_active,
  input  wire logic            overvoltage_low_level,
  input  wire logic            overvoltage_high_level,
  input  wire logic            output_undervoltage_level,
  output logic                 switch_gate,
  output logic      [TW-1:0]   boost_target,
  output logic                 spread_enable,
  output logic                 fault_recovery,
  output logic                 irq
);
  import bsc_pkg::*;

  localparam logic [TW-1:0] TGT_INIT =
    TW'(int'(TGT_MIN) + ((int'(TGT_MAX) - int'(TGT_MIN)) * INIT_PCT) / 100);

  // pins cross into hclk through two flops; stage 1 feeds stage 2 only
  localparam int unsigned NSYN = 4 * NCH + 5;
  logic [NSYN-1:0] syn1;
  logic [NSYN-1:0] syn2;
  logic            sync_d;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      syn1   <= '0;
      syn2   <= '0;
      sync_d <= 1'b0;
    end
    else
    begin
      syn1   <= {boost_clock_sync_pin, string_config_strap, string_fault,
                 sink_below_headroom, sink_at_headroom, channels_active,
                 overvoltage_low_level, overvoltage_high_level,
                 output_undervoltage_level};
      syn2   <= syn1;
      sync_d <= syn2[NSYN-1];
    end
  end
  logic           sync_s, act_s, ovl_s, ovh_s, uv_s;
  logic [NCH-1:0] strap_s, fault_s, below_s, at_s;
  assign {sync_s, strap_s, fault_s, below_s, at_s, act_s, ovl_s, ovh_s, uv_s} = syn2;
  logic sync_edge;
  assign sync_edge = syn2[NSYN-1] & ~sync_d;

  // AHB-Lite slave: zero wait states, always OKAY
  logic            ctrl_en, rec_clr;
  logic [PW-1:0]   period_r, duty_r;
  logic [NST-1:0]  status, mask;
  logic [NST-1:0]  ev;
  logic            wr_pend, next_wr_pend;
  logic [7:0]      wr_addr, next_wr_addr;
  logic [31:0]     next_hrdata;
  logic            next_ctrl_en;
  logic [PW-1:0]   next_period_r, next_duty_r;
  logic [NST-1:0]  next_status, next_mask, status_clr;
  logic [NCH-1:0]  in_use;
  bsc_mode_e       mode;
  logic            addr_ok;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_ok   = hsel & hready & htrans[1];

  always_comb
  begin
    next_wr_pend  = addr_ok & hwrite;
    next_wr_addr  = haddr[7:0];
    next_hrdata   = hrdata;
    next_ctrl_en  = ctrl_en;
    next_period_r = period_r;
    next_duty_r   = duty_r;
    next_mask     = mask;
    status_clr    = '0;
    rec_clr       = 1'b0;
    if (addr_ok && !hwrite)
    begin
      case (haddr[7:0])
        OFS_CTRL:   next_hrdata = {31'h0000_0000, ctrl_en};
        OFS_PERIOD: next_hrdata = {20'h00000, period_r};
        OFS_DUTY:   next_hrdata = {20'h00000, duty_r};
        OFS_STATUS: next_hrdata = {28'h0000000, status};
        OFS_MASK:   next_hrdata = {28'h0000000, mask};
        OFS_STATE:  next_hrdata = {16'h0000, in_use, 1'b0, fault_recovery,
                                   spread_enable, mode == CM_EXTERNAL, boost_target};
        default:    next_hrdata = 32'h0000_0000;
      endcase
    end
    if (wr_pend)
    begin
      case (wr_addr)
        OFS_CTRL:
        begin
          next_ctrl_en = hwdata[CTRL_EN_BIT];
          rec_clr      = hwdata[CTRL_RECOVER_BIT];
        end
        OFS_PERIOD: next_period_r = hwdata[PW-1:0];
        OFS_DUTY:   next_duty_r   = hwdata[PW-1:0];
        OFS_STATUS: status_clr    = hwdata[NST-1:0];
        OFS_MASK:   next_mask     = hwdata[NST-1:0];
        default:    next_mask     = mask;
      endcase
    end
    // a new event wins over a clear in the same cycle
    next_status = (status & ~status_clr) | ev;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend  <= 1'b0;
      wr_addr  <= 8'h00;
      hrdata   <= 32'h0000_0000;
      ctrl_en  <= 1'b0;
      period_r <= PERIOD_RST;
      duty_r   <= DUTY_RST;
      status   <= '0;
      mask     <= '0;
    end
    else
    begin
      wr_pend  <= next_wr_pend;
      wr_addr  <= next_wr_addr;
      hrdata   <= next_hrdata;
      ctrl_en  <= next_ctrl_en;
      period_r <= next_period_r;
      duty_r   <= next_duty_r;
      status   <= next_status;
      mask     <= next_mask;
    end
  end
  assign irq = |(status & mask);

  // sync clock detection and clock mode
  logic [PW-1:0] gap, next_gap, last_gap, next_last_gap;
  bsc_mode_e     next_mode;
  logic          next_spread, gap_ok, gap_over, sync_lost_ev;
  assign gap_ok   = (gap >= SYNC_MIN_PER_CYC) && (gap <= SYNC_MAX_PER_CYC);
  assign gap_over = gap > SYNC_MAX_PER_CYC;

  always_comb
  begin
    next_mode     = mode;
    next_last_gap = last_gap;
    next_gap      = gap_over ? gap : gap + 12'h001;
    sync_lost_ev  = 1'b0;
    if (sync_edge)
    begin
      next_gap      = 12'h001;
      next_last_gap = gap;
      // a period out of range does not switch to the external clock
      if (gap_ok)
        next_mode = CM_EXTERNAL;
    end
    else if (gap_over)
    begin
      case (mode)
        CM_DETECT:   next_mode = CM_INTERNAL;
        CM_EXTERNAL:
        begin
          next_mode        = CM_INTERNAL;
          sync_lost_ev     = 1'b1;
        end
        default:     next_mode = mode;
      endcase
    end
    // spread follows the settled pin level only without a clock
    next_spread = (next_mode == CM_INTERNAL) && sync_s;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mode          <= CM_DETECT;
      gap           <= '0;
      last_gap      <= '0;
      spread_enable <= 1'b0;
    end
    else
    begin
      mode          <= next_mode;
      gap           <= next_gap;
      last_gap      <= next_last_gap;
      spread_enable <= next_spread;
    end
  end

  // faults
  logic [31:0] uv_cnt, next_uv_cnt;
  logic        next_recovery, uv_expire;
  assign uv_expire = uv_s && (uv_cnt == 32'(UV_TIMEOUT_CYCLES - 1));
  always_comb
  begin
    next_uv_cnt   = uv_s ? uv_cnt + 32'h0000_0001 : 32'h0000_0000;
    if (uv_expire)
      next_uv_cnt = 32'h0000_0000;
    ev[ST_OVL]    = ovl_s;
    ev[ST_OVH]    = ovh_s;
    ev[ST_UVT]    = uv_expire;
    ev[ST_SYNC_LOST] = sync_lost_ev;
    // recovery is left only by software, and never while high overvoltage stands
    next_recovery = (fault_recovery & ~rec_clr) | ovh_s | uv_expire;
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      uv_cnt         <= '0;
      fault_recovery <= 1'b0;
    end
    else
    begin
      uv_cnt         <= next_uv_cnt;
      fault_recovery <= next_recovery;
    end
  end

  // adaptive target loop; strap read once after it has crossed in
  logic [1:0]     strap_wait, next_strap_wait;
  logic [NCH-1:0] next_in_use, mon;
  logic [11:0]    chk_cnt, next_chk_cnt;
  logic [TW-1:0]  next_target;
  logic           chk;
  assign mon = in_use & ~fault_s;
  assign chk = chk_cnt == 12'(CHECK_CYC - 1);
  always_comb
  begin
    next_strap_wait = (strap_wait == 2'h3) ? strap_wait : strap_wait + 2'h1;
    next_in_use     = (strap_wait == 2'h2) ? strap_s : in_use;
    next_chk_cnt    = chk ? 12'h000 : chk_cnt + 12'h001;
    next_target     = boost_target;
    if (chk)
    begin
      if (!act_s)
      begin
        if (boost_target < TGT_INIT)
          next_target = boost_target + 1'b1;
      end
      else if (|(below_s & mon))
      begin
        if (boost_target != TGT_MAX)
          next_target = boost_target + 1'b1;
      end
      else if (!(|(at_s & mon)) && boost_target != TGT_MIN)
        next_target = boost_target - 1'b1;
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      strap_wait   <= 2'h0;
      in_use       <= '0;
      chk_cnt      <= '0;
      boost_target <= TGT_MIN;
    end
    else
    begin
      strap_wait   <= next_strap_wait;
      in_use       <= next_in_use;
      chk_cnt      <= next_chk_cnt;
      boost_target <= next_target;
    end
  end

  // switching cycle
  function automatic logic [PW-1:0] on_width(input logic [PW-1:0] duty,
                                            input logic [PW-1:0] per);
    logic [PW-1:0] mon_c, moff_c, lim;
    begin
      mon_c  = (per <= FAST_BAND_CYC) ? MIN_ON_FAST_CYC  : MIN_ON_SLOW_CYC;
      moff_c = (per <= FAST_BAND_CYC) ? MIN_OFF_FAST_CYC : MIN_OFF_SLOW_CYC;
      lim    = (per > moff_c) ? per - moff_c : '0;
      if (duty > lim)
        on_width = lim;
      else if (duty < mon_c)
        on_width = (lim >= mon_c) ? mon_c : '0;
      else
        on_width = duty;
    end
  endfunction : on_width

  logic [PW-1:0] ph, next_ph, sp, next_sp, per_eff, on_eff;
  logic          sp_up, next_sp_up, next_gate, force_off, restart;
  // spread as a triangle of about +-1.6 % stepped once per cycle
  assign per_eff = (mode == CM_EXTERNAL) ? last_gap
                 : spread_enable ? period_r - (period_r >> 6) + sp : period_r;
  assign on_eff    = on_width(duty_r, per_eff);
  assign force_off = !ctrl_en || ovl_s || fault_recovery || mode == CM_DETECT;
  assign restart   = (mode == CM_EXTERNAL) ? sync_edge : (ph + 12'h001 >= per_eff);

  always_comb
  begin
    next_ph    = restart ? 12'h000 : ph + 12'h001;
    next_sp    = sp;
    next_sp_up = sp_up;
    if (restart && spread_enable)
    begin
      if (sp_up && sp < (period_r >> 5))
        next_sp = sp + 12'h001;
      else if (!sp_up && sp != 12'h000)
        next_sp = sp - 12'h001;
      else
        next_sp_up = !sp_up;
    end
    // a pulse only starts with a cycle, so a late release cannot make a runt
    next_gate = !force_off && (next_ph < on_eff) && (switch_gate || restart);
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ph          <= '0;
      sp          <= '0;
      sp_up       <= 1'b1;
      switch_gate <= 1'b0;
    end
    else
    begin
      ph          <= next_ph;
      sp          <= next_sp;
      sp_up       <= next_sp_up;
      switch_gate <= next_gate;
    end
  end

  logic [PW-1:0] on_len;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      on_len <= '0;
    else
      on_len <= switch_gate ? on_len + 12'h001 : 12'h000;
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  ovl_gate_off_a: assert property (ovl_s |=> !switch_gate ##1 status[ST_OVL])
    else $error("gate not stopped on low overvoltage");
  ovh_recovery_a: assert property (ovh_s |=> fault_recovery && status[ST_OVH])
    else $error("high overvoltage did not enter recovery");
  uv_timeout_a: assert property (uv_expire |=> fault_recovery && status[ST_UVT])
    else $error("undervoltage timeout not taken");
  flag_sticky_a: assert property (status[ST_OVH] && !status_clr[ST_OVH] |=> status[ST_OVH])
    else $error("fault flag dropped without clear");
  min_on_a: assert property ($fell(switch_gate) && !$past(force_off)
                             |-> on_len >= (($past(per_eff) <= FAST_BAND_CYC) ?
                                            MIN_ON_FAST_CYC : MIN_ON_SLOW_CYC))
    else $error("switch on pulse too short");
  ext_no_spread_a: assert property (mode == CM_EXTERNAL |-> !spread_enable)
    else $error("spread enabled with external clock");
  spread_level_a: assert property (mode == CM_INTERNAL && sync_s && !gap_ok
                                   ##1 mode == CM_INTERNAL |-> spread_enable)
    else $error("spread does not follow pin level");
  raise_a: assert property (chk && act_s && |(below_s & mon) && boost_target != TGT_MAX
                            |=> boost_target == $past(boost_target) + 1'b1)
    else $error("target not raised");
  lower_a: assert property (chk && act_s && !(|(below_s & mon)) && !(|(at_s & mon))
                            && boost_target != TGT_MIN
                            |=> boost_target == $past(boost_target) - 1'b1)
    else $error("target not lowered");
  masked_sink_a: assert property (chk && act_s && !(|(below_s & mon))
                                  |=> boost_target <= $past(boost_target))
    else $error("unmonitored sink raised target");
  fallback_a: assert property (mode == CM_DETECT && gap_over && !sync_edge
                               |=> mode == CM_INTERNAL)
    else $error("no fallback to internal clock");

  ext_mode_c: cover property (mode == CM_EXTERNAL ##1 mode == CM_INTERNAL);
  uv_c:       cover property (uv_expire);
  raise_c:    cover property (chk && act_s && |(below_s & mon));
  ovl_c:      cover property (switch_gate ##1 ovl_s);
endmodule : bsc_top
`default_nettype wire

// File: bsc_pkg.sv
`default_nettype none
package bsc_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned PW      = 12;
  localparam int unsigned NST     = 4;

  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_PERIOD = 8'h04;
  localparam logic [7:0] OFS_DUTY   = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_MASK   = 8'h10;
  localparam logic [7:0] OFS_STATE  = 8'h14;

  localparam int unsigned CTRL_EN_BIT      = 0;
  localparam int unsigned CTRL_RECOVER_BIT = 1;
  localparam int unsigned ST_OVL           = 0;
  localparam int unsigned ST_OVH           = 1;
  localparam int unsigned ST_UVT           = 2;
  localparam int unsigned ST_SYNC_LOST     = 3;
  localparam int unsigned STATE_TGT_LSB    = 0;
  localparam int unsigned STATE_EXT_BIT    = 8;
  localparam int unsigned STATE_SPREAD_BIT = 9;
  localparam int unsigned STATE_REC_BIT    = 10;
  localparam int unsigned STATE_INUSE_LSB  = 12;

  localparam logic [PW-1:0] PERIOD_RST = 12'h0FA;
  localparam logic [PW-1:0] DUTY_RST   = 12'h064;

  localparam int unsigned MIN_OFF_SLOW_NS = 150;
  localparam int unsigned MIN_ON_SLOW_NS  = 150;
  localparam int unsigned MIN_OFF_FAST_NS = 40;
  localparam int unsigned MIN_ON_FAST_NS  = 110;
  localparam logic [PW-1:0] MIN_OFF_SLOW_CYC = PW'((MIN_OFF_SLOW_NS * CLK_MHZ + 999) / 1000);
  localparam logic [PW-1:0] MIN_ON_SLOW_CYC  = PW'((MIN_ON_SLOW_NS * CLK_MHZ + 999) / 1000);
  localparam logic [PW-1:0] MIN_OFF_FAST_CYC = PW'((MIN_OFF_FAST_NS * CLK_MHZ + 999) / 1000);
  localparam logic [PW-1:0] MIN_ON_FAST_CYC  = PW'((MIN_ON_FAST_NS * CLK_MHZ + 999) / 1000);
  localparam int unsigned FAST_BAND_NS = 550;
  localparam logic [PW-1:0] FAST_BAND_CYC = PW'((FAST_BAND_NS * CLK_MHZ) / 1000);

  localparam int unsigned SYNC_MIN_KHZ = 100;
  localparam int unsigned SYNC_MAX_KHZ = 2222;
  localparam logic [PW-1:0] SYNC_MAX_PER_CYC = PW'((CLK_MHZ * 1000) / SYNC_MIN_KHZ);
  localparam logic [PW-1:0] SYNC_MIN_PER_CYC = PW'((CLK_MHZ * 1000) / SYNC_MAX_KHZ);

  localparam int unsigned UV_TIMEOUT_MS  = 110;
  localparam int unsigned UV_TIMEOUT_CYC = UV_TIMEOUT_MS * CLK_MHZ * 1000;
  localparam int unsigned CHECK_US       = 10;
  localparam int unsigned CHECK_CYC      = CHECK_US * CLK_MHZ;
  localparam int unsigned INIT_PCT       = 88;

  typedef enum logic [1:0] {
    CM_DETECT   = 2'b00,
    CM_INTERNAL = 2'b01,
    CM_EXTERNAL = 2'b10
  } bsc_mode_e;
endpackage : bsc_pkg
`default_nettype wire

// File: bsc_stage_model.sv
`timescale 1ns/10ps
`default_nettype none
module bsc_stage_model (
  input  wire logic  hclk,
  input  wire logic  switch_gate,
  input  wire logic  clr,
  input  wire logic  sync_run,
  input  wire logic  sync_idle,
  input  var  int    sync_half,
  output logic       boost_clock_sync_pin,
  output int         min_on,
  output int         min_off,
  output int         last_per,
  output int         nrise
);
  int   run;
  int   since;
  logic gq;
  logic seen;

  // the source stands at a static level between bursts, never free-running
  always
  begin
    if (sync_run)
    begin
      #(sync_half) boost_clock_sync_pin = ~boost_clock_sync_pin;
    end
    else
    begin
      boost_clock_sync_pin = sync_idle;
      @(sync_run or sync_idle);
      // keep pin edges off the sampling clock edge
      #2;
    end
  end

  // first edge after clr closes a partial run, so it is not measured
  always @(posedge hclk)
  begin
    gq <= switch_gate;
    if (clr)
    begin
      min_on  <= 9999;
      min_off <= 9999;
      nrise   <= 0;
      seen    <= 1'b0;
      run     <= 0;
      since   <= 0;
    end
    else if (switch_gate !== gq)
    begin
      seen <= 1'b1;
      run  <= 1;
      if (seen && gq && run < min_on)
        min_on <= run;
      if (seen && !gq && run < min_off)
        min_off <= run;
      if (switch_gate)
      begin
        nrise <= nrise + 1;
        if (nrise != 0)
          last_per <= since;
        since <= 1;
      end
      else
        since <= since + 1;
    end
    else
    begin
      run   <= run + 1;
      since <= since + 1;
    end
  end
endmodule : bsc_stage_model
`default_nettype wire

// File: boost_supervisor_clock_mode_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module boost_supervisor_clock_mode_tb_top;
  import bsc_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn, hsel, hwrite, hreadyout, hresp, sync_pin;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  strap, fault, below, at;
  logic        chan, ovl, ovh, uv, gate, spread, recov, irq, clr, sync_run, sync_idle;
  logic [7:0]  target;
  int          sync_half, min_on, min_off, last_per, nrise, miscompares, n_compared;
  int          cyc, n, w;
  int          per_t[4] = '{250, 250, 50, 50};
  int          dut_t[4] = '{1, 249, 2, 49};
  int          lim_t[4] = '{150 / 10, 150 / 10, 110 / 10, 40 / 10};

  always #5 hclk = ~hclk;

  bsc_top #(.TW(8), .NCH(4), .TGT_MIN(8'h00), .TGT_MAX(8'h10), .UV_TIMEOUT_CYCLES(200)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .boost_clock_sync_pin(sync_pin),
    .string_config_strap(strap), .string_fault(fault), .sink_below_headroom(below),
    .sink_at_headroom(at), .channels_active(chan), .overvoltage_low_level(ovl),
    .overvoltage_high_level(ovh), .output_undervoltage_level(uv), .switch_gate(gate),
    .boost_target(target), .spread_enable(spread), .fault_recovery(recov), .irq(irq));

  bsc_stage_model stage_u (
    .hclk(hclk), .switch_gate(gate), .clr(clr), .sync_run(sync_run), .sync_idle(sync_idle),
    .sync_half(sync_half), .boost_clock_sync_pin(sync_pin), .min_on(min_on),
    .min_off(min_off), .last_per(last_per), .nrise(nrise));

  task end_of_test;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask : chk

  task automatic wc(input int k);
    repeat (k) @(posedge hclk);
  endtask : wc

  // one single word transfer; only the global timeout ends a wait
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    #1;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] k, input logic [31:0] e,
                     input string m);
    logic [31:0] d;
    bus(1'b0, a, 32'h00000000, d);
    chk(d & k, e, m);
  endtask : rdc

  task automatic pclr;
    wc(1);
    clr <= 1'b1;
    wc(1);
    clr <= 1'b0;
  endtask : pclr

  task automatic step(input logic c, input logic [3:0] b, input logic [3:0] f,
                      input logic [3:0] a, input logic [7:0] e, input int k);
    wc(1);
    chan  <= c;
    below <= b;
    fault <= f;
    at    <= a;
    wc(k);
    #1;
    chk(32'(target), 32'(e), "target");
  endtask : step

  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      miscompares++;
      $display("[FAIL] %0t timeout", $time);
      end_of_test();
    end
  end

  initial
  begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; strap = 4'h7; fault = 4'h0; below = 4'h0; at = 4'h0;
    chan = 1'b0; ovl = 1'b0; ovh = 1'b0; uv = 1'b0; clr = 1'b1;
    sync_run = 1'b0; sync_idle = 1'b1; sync_half = 1000;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(OFS_PERIOD, 32'h00000FFF, 32'h000000FA, "period");
    rdc(OFS_DUTY, 32'h00000FFF, 32'h00000064, "duty");
    rdc(OFS_STATUS, 32'hFFFFFFFF, 32'h0, "status");
    rdc(8'h20, 32'hFFFFFFFF, 32'h0, "unmapped");
    chk(32'(hresp), 32'h0, "hresp okay");
    wr(OFS_STATE, 32'h0);
    rdc(OFS_STATE, 32'h0000F000, 32'h00007000, "in use");
    wc(1200);
    #1;
    chk(32'(spread), 32'h1, "spread high pin");
    rdc(OFS_STATE, 32'h00000100, 32'h0, "internal at start");
    $display("test regs done");
    n = 0;
    while (target !== 8'h0E && n++ < 20000)
    begin
      @(posedge hclk);
      #1;
    end
    chk(32'(target), 32'h0E, "init level");
    wc(10);
    // ticks every 1000 cycles; each step drifts one cycle against the tick, so counts stay exact
    step(1'b0, 4'h0, 4'h0, 4'h0, 8'h0E, 2000);
    step(1'b1, 4'h8, 4'h0, 4'h0, 8'h0B, 3000);
    step(1'b1, 4'h8, 4'h0, 4'h1, 8'h0B, 3000);
    step(1'b1, 4'hA, 4'h2, 4'h1, 8'h0B, 3000);
    step(1'b1, 4'hA, 4'h0, 4'h1, 8'h0E, 3000);
    $display("test loop done");
    wr(OFS_CTRL, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      wr(OFS_PERIOD, 32'(per_t[i]));
      wr(OFS_DUTY, 32'(dut_t[i]));
      pclr();
      wc(1500);
      w = (i % 2 == 0) ? min_on : min_off;
      chk(32'(w >= lim_t[i] && w < 9999), 32'h1, "min width");
    end
    wr(OFS_PERIOD, 32'h000000FA);
    wr(OFS_DUTY, 32'h00000064);
    ovl <= 1'b1;
    wc(4);
    pclr();
    wc(300);
    chk(32'(nrise == 0 && recov === 1'b0), 32'h1, "ovl stop");
    rdc(OFS_STATUS, 32'hF, 32'h1, "ovl flag");
    chk(32'(irq), 32'h0, "masked irq");
    ovl <= 1'b0;
    pclr();
    wc(600);
    chk(32'(nrise > 0), 32'h1, "ovl resume");
    rdc(OFS_STATUS, 32'hF, 32'h1, "ovl sticky");
    wr(OFS_MASK, 32'hF);
    chk(32'(irq), 32'h1, "irq on");
    wr(OFS_STATUS, 32'h1);
    chk(32'(irq), 32'h0, "irq cleared");
    wc(1);
    ovh <= 1'b1;
    wc(5);
    ovh <= 1'b0;
    pclr();
    wc(300);
    chk(32'(recov === 1'b1 && nrise == 0), 32'h1, "ovh recovery");
    rdc(OFS_STATUS, 32'hF, 32'h2, "ovh flag");
    wr(OFS_CTRL, 32'h3);
    wr(OFS_STATUS, 32'h2);
    chk(32'(recov), 32'h0, "recovered");
    wc(1);
    uv <= 1'b1;
    wc(150);
    uv <= 1'b0;
    wc(100);
    rdc(OFS_STATUS, 32'hF, 32'h0, "uv short");
    wc(1);
    uv <= 1'b1;
    wc(260);
    uv <= 1'b0;
    #1;
    chk(32'(recov), 32'h1, "uv recovery");
    rdc(OFS_STATUS, 32'hF, 32'h4, "uv flag");
    wr(OFS_CTRL, 32'h3);
    wr(OFS_STATUS, 32'h4);
    $display("test faults done");
    wc(1);
    sync_half <= 80;
    sync_run  <= 1'b1;
    wc(3000);
    rdc(OFS_STATE, 32'h00000100, 32'h0, "too fast");
    sync_half <= 1000;
    wc(1500);
    rdc(OFS_STATE, 32'h00000100, 32'h00000100, "external");
    chk(32'(spread), 32'h0, "spread off ext");
    pclr();
    wc(700);
    chk(32'(last_per), 32'd200, "ext period");
    sync_idle <= 1'b1;
    sync_run  <= 1'b0;
    wc(1500);
    rdc(OFS_STATE, 32'h00000100, 32'h0, "fallback");
    rdc(OFS_STATUS, 32'h8, 32'h8, "sync lost");
    chk(32'(spread), 32'h1, "final high");
    wc(1);
    sync_idle <= 1'b0;
    wc(50);
    #1;
    chk(32'(spread), 32'h0, "pin low");
    pclr();
    wc(1200);
    chk(32'(last_per), 32'd250, "internal period");
    $display("test sync done");
    end_of_test();
  end
endmodule : boost_supervisor_clock_mode_tb_top
`default_nettype wire
